// ---- rtl/fer_pkg.sv ----
// Constants, types and carriers for the floating-point exception reporting unit
package fer_pkg;

    // Exception class positions in flags and masks
    localparam int EXC_INVALID = 0;
    localparam int EXC_DENORM = 1;
    localparam int EXC_ZDIV = 2;
    localparam int EXC_OVER = 3;
    localparam int EXC_UNDER = 4;
    localparam int EXC_PREC = 5;
    localparam int EXC_N = 6;

    // Register offsets (byte addresses)
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_STATUS = 8'h04;

    // Control field positions
    localparam int CTRL_ROUND_LSB = 6;
    localparam int CTRL_NATIVE_BIT = 8;
    // Status field positions
    localparam int STAT_SF_BIT = 6;
    localparam int STAT_ERR_BIT = 7;
    localparam int STAT_FRZ_BIT = 8;

    // Values after reset: all classes masked, nearest, compatibility mode
    localparam logic [5:0] MASK_RST = 6'h3f;
    localparam logic [1:0] ROUND_RST = 2'h0;
    localparam logic NATIVE_RST = 1'b0;

    // Instruction kinds reported by the core
    typedef enum logic [2:0] {
        IK_ARITH = 3'h0,
        IK_WAIT = 3'h1,
        IK_NOWAIT = 3'h2,
        IK_CLEAR = 3'h3,
        IK_REINIT = 3'h4,
        IK_SAVE = 3'h5,
        IK_RESTORE = 3'h6
    } fer_instr_e;

    // Default fix-up applied by the arithmetic for a masked exception
    typedef enum logic [2:0] {
        FX_NONE = 3'h0,
        FX_QNAN = 3'h1,
        FX_INF = 3'h2,
        FX_DENORM = 3'h3,
        FX_ZERO = 3'h4,
        FX_ROUNDED = 3'h5
    } fer_fixup_e;

    // Freeze sequencer, Gray coded along run, frozen, release
    typedef enum logic [1:0] {
        ST_RUN = 2'b00,
        ST_FROZEN = 2'b01,
        ST_RELEASE = 2'b11
    } fer_state_e;

    // Core-side request carrier, same clock as the unit
    typedef struct packed {
        logic instr_valid;
        fer_instr_e instr_kind;
        logic [EXC_N-1:0] env_flags;
        logic env_sf;
        logic exc_valid;
        logic stack_fault_exc;
        logic standard_invalid_exc;
        logic denorm_exc;
        logic zdiv_exc;
        logic over_exc;
        logic under_exc;
        logic prec_exc;
        logic exc_deferred;
        logic below_min_denorm;
    } fer_core_s;

    // Register bus carrier
    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } fer_bus_s;

endpackage : fer_pkg

// ---- rtl/fer_top.sv ----
// Floating-point exception recognition, sticky flags and error-pin reporting
//
// The placing of the registers and the strobed register port were chosen for this implementation.
`timescale 1ns/1ps
module fer_top
    import fer_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire fer_bus_s bus,
    output logic [31:0] rdata,
    input wire fer_core_s core,
    input wire logic ignore_numeric_error_in,
    input wire logic maskable_interrupt_in,
    output logic fp_error_out,
    output logic core_freeze,
    output logic instr_abort,
    output logic handler_req,
    output fer_fixup_e fixup,
    output logic [1:0] round_mode
);

    // Whole module state in one record
    typedef struct packed {
        fer_state_e state;
        logic [EXC_N-1:0] mask;
        logic [1:0] round;
        logic native;
        logic [EXC_N-1:0] flags;
        logic sf;
        logic reported;
        logic deferred;
        logic ign_s1;
        logic ign_s2;
        logic int_s1;
        logic int_s2;
        logic err;
        logic freeze;
        logic abort;
        logic hreq;
        fer_fixup_e fix;
        logic [31:0] rdata;
    } fer_reg_s;

    fer_reg_s st_reg;
    fer_reg_s st_next;

    // Arithmetic and wait instructions are where a pending error is honoured
    function automatic logic fer_is_sync(input fer_instr_e k);
        fer_is_sync = (k == IK_ARITH) || (k == IK_WAIT);
    endfunction : fer_is_sync

    // Instructions that wipe the sticky flags
    function automatic logic fer_is_wipe(input fer_instr_e k);
        fer_is_wipe = (k == IK_CLEAR) || (k == IK_REINIT) || (k == IK_SAVE);
    endfunction : fer_is_wipe

    // Next-state logic
    always_comb begin
        logic [EXC_N-1:0] raw;
        logic [EXC_N-1:0] unmasked;
        logic pending;
        logic sync_hit;
        logic compat;
        raw = '0;
        unmasked = '0;
        pending = 1'b0;
        sync_hit = 1'b0;
        compat = 1'b0;
        st_next = st_reg;
        st_next.rdata = 32'h0;
        st_next.abort = 1'b0;
        st_next.hreq = 1'b0;
        st_next.fix = FX_NONE;

        // Pins are foreign to mclk: two flops before use
        st_next.ign_s1 = ignore_numeric_error_in;
        st_next.ign_s2 = st_reg.ign_s1;
        st_next.int_s1 = maskable_interrupt_in;
        st_next.int_s2 = st_reg.int_s1;

        // Register reads, data one cycle later
        if (bus.rd) begin
            if (bus.addr == OFS_CTRL) begin
                st_next.rdata[EXC_N-1:0] = st_reg.mask;
                st_next.rdata[CTRL_ROUND_LSB+:2] = st_reg.round;
                st_next.rdata[CTRL_NATIVE_BIT] = st_reg.native;
            end else if (bus.addr == OFS_STATUS) begin
                st_next.rdata[EXC_N-1:0] = st_reg.flags;
                st_next.rdata[STAT_SF_BIT] = st_reg.sf;
                st_next.rdata[STAT_ERR_BIT] = st_reg.err;
                st_next.rdata[STAT_FRZ_BIT] = st_reg.freeze;
            end else begin
                // Unmapped reads return zero
                st_next.rdata = 32'h0;
            end
        end

        // Register writes steer masks, rounding and reporting mode
        if (bus.wr) begin
            if (bus.addr == OFS_CTRL) begin
                st_next.mask = bus.wdata[EXC_N-1:0];
                st_next.round = bus.wdata[CTRL_ROUND_LSB+:2];
                st_next.native = bus.wdata[CTRL_NATIVE_BIT];
            end else if (bus.addr == OFS_STATUS) begin
                // Software overwrite of the flags, as an environment load
                st_next.flags = bus.wdata[EXC_N-1:0];
                st_next.sf = bus.wdata[STAT_SF_BIT];
            end
        end

        // Flag-clearing instructions; the only hardware path that clears
        if (core.instr_valid) begin
            if (fer_is_wipe(core.instr_kind)) begin
                st_next.flags = '0;
                st_next.sf = 1'b0;
            end else if (core.instr_kind == IK_RESTORE) begin
                st_next.flags = core.env_flags;
                st_next.sf = core.env_sf;
            end
            if (core.instr_kind == IK_REINIT) begin
                st_next.mask = MASK_RST;
                st_next.round = ROUND_RST;
            end
        end

        // Exception capture: set is applied after clears so it wins
        if (core.exc_valid) begin
            raw[EXC_INVALID] = core.stack_fault_exc | core.standard_invalid_exc;
            raw[EXC_DENORM] = core.denorm_exc;
            raw[EXC_ZDIV] = core.zdiv_exc;
            raw[EXC_OVER] = core.over_exc;
            raw[EXC_UNDER] = core.under_exc;
            raw[EXC_PREC] = core.prec_exc;
            // Several classes may land in one event
            st_next.flags = st_next.flags | raw;
            st_next.sf = st_next.sf | core.stack_fault_exc;
        end
        unmasked = raw & ~st_reg.mask;

        // Masked classes: tell the arithmetic which default to deliver
        if (core.exc_valid && (unmasked == '0)) begin
            // Only the flag records it, no pin, no location
            if (raw[EXC_INVALID]) begin
                st_next.fix = FX_QNAN;
            end else if (raw[EXC_ZDIV]) begin
                // One divided by zero gives infinity
                st_next.fix = FX_INF;
            end else if (raw[EXC_OVER]) begin
                st_next.fix = FX_INF;
            end else if (raw[EXC_UNDER]) begin
                // Too small for normal form
                st_next.fix = core.below_min_denorm ? FX_ZERO : FX_DENORM;
            end else if (raw[EXC_PREC]) begin
                // Rounded by the mode on round_mode
                st_next.fix = FX_ROUNDED;
            end
        end

        // Unmasked class: stop the faulting instruction
        if (unmasked != '0) begin
            st_next.abort = 1'b1;
            if (core.exc_deferred) begin
                st_next.deferred = 1'b1;
            end else begin
                st_next.reported = 1'b1;
            end
        end

        // Pending means an unmasked class still sits in the flags
        pending = (st_next.flags & ~st_next.mask) != '0;
        compat = ~st_next.native;
        sync_hit = core.instr_valid && fer_is_sync(core.instr_kind);

        // A deferred error is reported at the next sync instruction
        if (pending && sync_hit) begin
            st_next.reported = 1'b1;
        end
        if (!pending) begin
            // Cleared inside the unit: reporting ends
            st_next.reported = 1'b0;
            st_next.deferred = 1'b0;
        end

        // Error level only in compatibility mode; also the coprocessor line
        st_next.err = compat && st_next.reported;

        // Freeze sequencer
        case (st_reg.state)
            ST_RUN: begin
                if (pending && sync_hit) begin
                    if (!compat) begin
                        // Native mode raises the handler directly
                        st_next.hreq = 1'b1;
                    end else if (!st_reg.ign_s2) begin
                        // Stop before the sync instruction
                        st_next.state = ST_FROZEN;
                        st_next.freeze = 1'b1;
                    end
                    // Ignore input active: carry on
                end
            end
            ST_FROZEN: begin
                // Any interrupt releases, not only the error one
                if (st_reg.int_s2) begin
                    st_next.state = ST_RELEASE;
                    st_next.freeze = 1'b0;
                end else if (!pending || st_reg.ign_s2 || !compat) begin
                    // Condition gone or now ignored
                    st_next.state = ST_RUN;
                    st_next.freeze = 1'b0;
                end
            end
            ST_RELEASE: begin
                // Wait for the interrupt level to fall so one request
                // does not unfreeze two instructions
                if (!st_reg.int_s2) begin
                    st_next.state = ST_RUN;
                end else if (pending && sync_hit && compat && !st_reg.ign_s2) begin
                    // Handler retried without clearing: freeze again
                    st_next.state = ST_FROZEN;
                    st_next.freeze = 1'b1;
                end
            end
            default: begin
                st_next.state = ST_RUN;
                st_next.freeze = 1'b0;
            end
        endcase
    end

    // State register, synchronous active-low reset
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            st_reg.state <= ST_RUN;
            st_reg.mask <= MASK_RST;
            st_reg.round <= ROUND_RST;
            st_reg.native <= NATIVE_RST;
            st_reg.flags <= '0;
            st_reg.sf <= 1'b0;
            st_reg.reported <= 1'b0;
            st_reg.deferred <= 1'b0;
            st_reg.ign_s1 <= 1'b0;
            st_reg.ign_s2 <= 1'b0;
            st_reg.int_s1 <= 1'b0;
            st_reg.int_s2 <= 1'b0;
            st_reg.err <= 1'b0;
            st_reg.freeze <= 1'b0;
            st_reg.abort <= 1'b0;
            st_reg.hreq <= 1'b0;
            st_reg.fix <= FX_NONE;
            st_reg.rdata <= 32'h0;
        end else begin
            st_reg <= st_next;
        end
    end

    // Outputs straight from the state record
    assign rdata = st_reg.rdata;
    assign fp_error_out = st_reg.err;
    assign core_freeze = st_reg.freeze;
    assign instr_abort = st_reg.abort;
    assign handler_req = st_reg.hreq;
    assign fixup = st_reg.fix;
    assign round_mode = st_reg.round;

endmodule : fer_top

// ---- tb/fer_intc_model.sv ----
// Interrupt controller model turning the error output into an interrupt
`timescale 1ns/1ps
module fer_intc_model (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic fp_error_out,
    input wire logic irq_enable,
    input wire logic slow,
    input wire logic req_clear,
    output logic maskable_interrupt_in
);
    logic err_d; // Error level of the last cycle
    logic req; // Latched request on the error request line
    logic [3:0] dly; // Wiring and priority delay stages
    // Edge latch: a still-high error never re-requests, as in real boards
    always_ff @(posedge mclk) begin
        if (!reset_n) begin
            err_d <= 1'b0;
            req <= 1'b0;
            dly <= 4'h0;
        end else begin
            err_d <= fp_error_out;
            if (fp_error_out && !err_d) begin
                req <= 1'b1;
            end else if (req_clear) begin
                req <= 1'b0;
            end
            dly <= {dly[2:0], req && irq_enable};
        end
    end
    // Prompt or slow answer toward the core
    assign maskable_interrupt_in = slow ? dly[3] : dly[0];
endmodule : fer_intc_model

// ---- tb/fer_properties.sv ----
// Port-level property checker for the exception reporting unit
`timescale 1ns/1ps
module fer_checker
    import fer_pkg::*;
(
    input wire logic mclk,
    input wire logic reset_n,
    input wire fer_bus_s bus,
    input wire logic [31:0] rdata,
    input wire fer_core_s core,
    input wire logic ignore_numeric_error_in,
    input wire logic maskable_interrupt_in,
    input wire logic fp_error_out,
    input wire logic core_freeze,
    input wire logic instr_abort,
    input wire logic handler_req,
    input wire fer_fixup_e fixup,
    input wire logic [1:0] round_mode
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
    // Read data stands only in the cycle after a read strobe
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");
    a_abort_cause: assert property (instr_abort |-> $past(core.exc_valid))
        else $error("abort without exception");
    a_fixup_cause: assert property (fixup != FX_NONE |-> $past(core.exc_valid))
        else $error("fix-up without exception");
    // A fix-up means every raised class was masked, so nothing may abort
    a_masked_quiet: assert property (fixup != FX_NONE |-> !instr_abort)
        else $error("masked exception aborted");
    a_freeze_cause: assert property ($rose(core_freeze) |-> $past(core.instr_valid)
        && ($past(core.instr_kind) inside {IK_ARITH, IK_WAIT})) else $error("bad freeze");
    a_freeze_error: assert property ($rose(core_freeze) |-> fp_error_out)
        else $error("freeze without error output");
    a_error_level: assert property ($rose(fp_error_out) |=> fp_error_out)
        else $error("error output pulsed");
    // Synchroniser latency bounds the release after a held input
    a_ignore_release: assert property (core_freeze && ignore_numeric_error_in ##1
        ignore_numeric_error_in [*2] |-> ##[1:3] !core_freeze) else $error("ignore held");
    a_int_release: assert property (core_freeze && maskable_interrupt_in ##1
        maskable_interrupt_in [*2] |-> ##[1:3] !core_freeze) else $error("int held");
    a_native_req: assert property (handler_req |-> $past(core.instr_valid)
        && !core_freeze) else $error("bad handler request");
    c_abort: cover property (instr_abort);
    c_inf: cover property (fixup == FX_INF);
    c_freeze: cover property ($rose(core_freeze));
    c_native: cover property (handler_req);
endmodule : fer_checker

bind fer_top fer_checker u_chk (
    .mclk, .reset_n, .bus, .rdata, .core, .ignore_numeric_error_in,
    .maskable_interrupt_in, .fp_error_out, .core_freeze, .instr_abort,
    .handler_req, .fixup, .round_mode
);

// ---- tb/tb.sv ----
// Directed testbench for the exception reporting unit
`timescale 1ns/1ps
module tb
    import fer_pkg::*;
;
    logic mclk;
    logic reset_n;
    fer_bus_s bus;
    logic [31:0] rdata;
    fer_core_s core;
    logic ign;
    logic irq;
    logic irq_en;
    logic slow;
    logic req_clr;
    logic fp_error_out;
    logic core_freeze;
    logic instr_abort;
    logic handler_req;
    fer_fixup_e fixup;
    logic [1:0] round_mode;
    int bad_count = 0;
    int cmp_count = 0;
    int cyc = 0;
    // Masked cases: class vector {sf,inv,den,zdiv,over,under,prec} and fix-up
    // Divide-by-zero alone gives infinity; denormal then underflow in one event
    logic [6:0] cv [7] = '{7'h40, 7'h08, 7'h02, 7'h02, 7'h01, 7'h12, 7'h24};
    fer_fixup_e fx [7] = '{FX_QNAN, FX_INF, FX_DENORM, FX_ZERO, FX_ROUNDED, FX_DENORM, FX_QNAN};
    fer_instr_e clr_k [3] = '{IK_CLEAR, IK_REINIT, IK_SAVE};

    fer_top DUT (.mclk(mclk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .core(core),
        .ignore_numeric_error_in(ign), .maskable_interrupt_in(irq),
        .fp_error_out(fp_error_out), .core_freeze(core_freeze), .instr_abort(instr_abort),
        .handler_req(handler_req), .fixup(fixup), .round_mode(round_mode));
    fer_intc_model intc (.mclk(mclk), .reset_n(reset_n), .fp_error_out(fp_error_out),
        .irq_enable(irq_en), .slow(slow), .req_clear(req_clr), .maskable_interrupt_in(irq));

    // Free-running core clock
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    // Hang guard: the directed run needs well under a thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            bad_count++;
            end_of_test();
        end
    end

    task end_of_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            bad_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask : wr
    // Read data is looked at in the one cycle where it stands
    task rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge mclk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
        @(negedge mclk);
        chk(rdata, exp);
    endtask : rd
    task exc(input logic [6:0] c, input logic dfr, input logic low);
        @(posedge mclk);
        core.exc_valid <= 1'b1;
        {core.stack_fault_exc, core.standard_invalid_exc, core.denorm_exc, core.zdiv_exc,
            core.over_exc, core.under_exc, core.prec_exc} <= c;
        core.exc_deferred <= dfr;
        core.below_min_denorm <= low;
        @(posedge mclk);
        core.exc_valid <= 1'b0;
        @(negedge mclk);
    endtask : exc
    task ins(input fer_instr_e k);
        @(posedge mclk);
        core.instr_valid <= 1'b1;
        core.instr_kind <= k;
        @(posedge mclk);
        core.instr_valid <= 1'b0;
        @(negedge mclk);
    endtask : ins
    // Bounded wait for the core to run again; a stuck freeze is a mismatch
    task wait_free();
        int n;
        n = 0;
        // Look only where the registered output has settled
        @(negedge mclk);
        while (core_freeze !== 1'b0 && n < 50) begin
            @(negedge mclk);
            n++;
        end
        chk(core_freeze, 0);
    endtask : wait_free
    // Handler writes the request-clear port before touching the flags
    task hclear();
        @(posedge mclk);
        req_clr <= 1'b1;
        @(posedge mclk);
        req_clr <= 1'b0;
    endtask : hclear

    initial begin
        bus = '0;
        core = '0;
        core.env_flags = 6'h15;
        core.env_sf = 1'b1;
        ign = 1'b0;
        irq_en = 1'b0;
        slow = 1'b1;
        req_clr = 1'b0;
        reset_n = 1'b0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        rd(OFS_CTRL, 32'h3f);
        rd(OFS_STATUS, 32'h0);
        rd(8'h08, 32'h0);
        for (int i = 0; i < 7; i++) begin
            exc(cv[i], 1'b0, i == 3);
            chk(fixup, fx[i]);
            chk({instr_abort, fp_error_out}, 0);
        end
        rd(OFS_STATUS, 32'h7f);
        for (int i = 0; i < 3; i++) begin
            exc(7'h01, 1'b0, 1'b0);
            ins(clr_k[i]);
            rd(OFS_STATUS, 32'h0);
        end
        ins(IK_RESTORE);
        rd(OFS_STATUS, 32'h55);
        ins(IK_CLEAR);
        for (int r = 0; r < 4; r++) begin
            wr(OFS_CTRL, {24'h0, r[1:0], 6'h3f});
            rd(OFS_CTRL, {24'h0, r[1:0], 6'h3f});
            chk({30'h0, round_mode}, r);
        end
        wr(OFS_CTRL, 32'h3b);
        exc(7'h08, 1'b0, 1'b0);
        chk({instr_abort, fp_error_out}, 3);
        ins(IK_ARITH);
        chk(core_freeze, 1);
        repeat (10) @(negedge mclk);
        chk({core_freeze, fp_error_out}, 3);
        @(posedge mclk) irq_en <= 1'b1;
        wait_free();
        hclear();
        ins(IK_NOWAIT);
        chk(core_freeze, 0);
        repeat (8) @(negedge mclk);
        ins(IK_ARITH);
        chk(core_freeze, 1);
        wr(OFS_STATUS, 32'h0);
        wait_free();
        chk(fp_error_out, 0);
        @(posedge mclk) irq_en <= 1'b0;
        exc(7'h08, 1'b0, 1'b0);
        @(posedge mclk) ign <= 1'b1;
        repeat (4) @(negedge mclk);
        ins(IK_ARITH);
        chk(core_freeze, 0);
        @(posedge mclk) ign <= 1'b0;
        repeat (4) @(negedge mclk);
        ins(IK_ARITH);
        chk(core_freeze, 1);
        @(posedge mclk) ign <= 1'b1;
        wait_free();
        @(posedge mclk) ign <= 1'b0;
        hclear();
        wr(OFS_STATUS, 32'h0);
        @(posedge mclk) irq_en <= 1'b1;
        slow <= 1'b0;
        exc(7'h08, 1'b1, 1'b0);
        chk(fp_error_out, 0);
        ins(IK_WAIT);
        chk({core_freeze, fp_error_out}, 3);
        wait_free();
        hclear();
        wr(OFS_STATUS, 32'h0);
        repeat (3) @(negedge mclk);
        chk(fp_error_out, 0);
        wr(OFS_CTRL, 32'h13b);
        exc(7'h08, 1'b0, 1'b0);
        chk({instr_abort, fp_error_out}, 2);
        ins(IK_ARITH);
        chk({handler_req, core_freeze}, 2);
        end_of_test();
    end
endmodule : tb
